//--- rtl/ppcr_regs.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Shutdown cause flags bits 7-5, write-one clears
// - Start-up cause flags bits 4-0, write-one clears
// - Status: over-temperature bit 7, charging bit 6
// - Battery present bit 5, valid when bit 4
// - Safe mode bit 3; bits 2-0 read zero
// - Fixed six-bit type code in bits 7-6,3-0
// - Twelve scratch bytes cleared only by power-on
// - Switcher enables bits 6,5,4,3,1,0 default on
// - Linear enables A bits 6-0, reset 08h
// - Linear enables B bits 7-2, reset 9ch
// - Bit 7 turns global reset into cold reset
// - Bit 2 starts cold reset, 64 ms off
// - Sleep-exit high, reset low 512 ms: cold reset
// - Bit 6 dual phase, bit 5 merges three/four
// - Bit 4 selects sleep voltage set
// - Bit 1 redirects writes to shadow, copies live
// - Bit 0 loads shadow, then clears bits 1-0
// - First digital linear voltage, five bits, 16h
// - Second digital linear voltage, five bits, 16h
module ppcr_regs #(
   parameter logic [5:0] TYPE_CODE = 6'h2a, // Arbitrary value
   parameter int unsigned COLD_DELAY_CYCLES = ppcr_pkg::COLD_DELAY_MS * ppcr_pkg::CLK_KHZ,
   parameter int unsigned LOW_HOLD_CYCLES = ppcr_pkg::LOW_HOLD_MS * ppcr_pkg::CLK_KHZ
) (
   // Clock and resets
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic por_srst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic pready_out,
   output logic [31:0] prdata_out,
   output logic pslverr_out,
   // Charger and thermal status pins
   input wire logic over_temp_in,
   input wire logic charging_in,
   input wire logic batt_present_in,
   input wire logic batt_detect_done_in,
   input wire logic batt_safe_mode_in,
   // Host pins
   input wire logic host_sleep_exit_n_in,
   input wire logic platform_reset_n_in,
   input wire logic host_global_reset_n_in,
   // Reason events from on-chip power logic
   input wire logic key_override_evt_in,
   input wire logic cold_off_evt_in,
   input wire logic uvlo_evt_in,
   input wire logic batt_insert_evt_in,
   input wire logic chg_insert_evt_in,
   input wire logic power_key_evt_in,
   // Rail control
   output logic [7:0] switcher_en_out,
   output logic [7:0] linear_a_en_out,
   output logic [7:0] linear_b_en_out,
   output logic [4:0] digital_linear_one_volt_out,
   output logic [4:0] digital_linear_two_volt_out,
   output logic switcher_five_dual_out,
   output logic switcher_three_four_poly_out,
   output logic sleep_set_sel_out,
   output logic rails_off_out
);
   logic sys_rst;
   logic [ppcr_pkg::SYNC_LANES-1:0] pin_raw;
   logic [ppcr_pkg::SYNC_LANES-1:0] pin_s1_r;
   logic [ppcr_pkg::SYNC_LANES-1:0] pin_s2_r;
   logic [ppcr_pkg::SYNC_LANES-1:0] pin_s3_r;
   logic [ppcr_pkg::SYNC_LANES-1:0] pin_r;
   logic glb_n_d_r;
   logic glb_evt;
   logic [5:0] idx;
   logic hit;
   logic [7:0] rd_byte;
   logic wr;
   logic [7:0] wd;
   logic [7:0] status;
   logic [7:0] reason_r;
   logic [7:0] reason_set;
   logic [7:0] reason_clr;
   logic [7:0] scratch_r [ppcr_pkg::SCR_COUNT];
   logic [7:0] sync_r;
   logic low_hold_r;
   logic [6:0] sync_sys_r;
   logic [7:0] sw_r, lin_a_r, lin_b_r, v1_r, v2_r;
   logic [7:0] sh_sw_r, sh_lin_a_r, sh_lin_b_r, sh_v1_r, sh_v2_r;
   logic shadow_on;
   logic shadow_enter;
   logic xfer;
   logic live_wr;
   logic sh_wr;
   logic [ppcr_pkg::CNT_W-1:0] hold_cnt_r;
   logic hold_cond;
   logic hold_fire;
   logic [ppcr_pkg::CNT_W-1:0] cold_cnt_r;
   logic cold_req;
   ppcr_pkg::ppcr_state_t state_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // Power-on reset also resets the system domain
   assign sys_rst = srst_in | por_srst_in;

   // Pin synchronisers: a change counts once stages two and three agree
   assign pin_raw = {host_global_reset_n_in, platform_reset_n_in, host_sleep_exit_n_in,
                     batt_safe_mode_in, batt_detect_done_in, batt_present_in,
                     charging_in, over_temp_in};
   generate
      for (genvar g = 0; g < ppcr_pkg::SYNC_LANES; g++) begin : g_sync
         always_ff @(posedge clock_in) begin
            pin_s1_r[g] <= pin_raw[g];
            pin_s2_r[g] <= pin_s1_r[g];
            pin_s3_r[g] <= pin_s2_r[g];
            if (sys_rst) begin
               pin_r[g] <= (g >= 5);
            end else if (pin_s2_r[g] == pin_s3_r[g]) begin
               pin_r[g] <= pin_s3_r[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         glb_n_d_r <= 1'b1;
      end else begin
         glb_n_d_r <= pin_r[7];
      end
   end
   assign glb_evt = glb_n_d_r & ~pin_r[7];

   // Status byte; low bits stay zero
   assign status = {pin_r[0], pin_r[1], pin_r[2], pin_r[3], pin_r[4], 3'b000};

   // APB decode
   assign idx = paddr_in[7:2];
   always_comb begin
      hit = (paddr_in[1:0] == 2'b00);
      rd_byte = 8'h00;
      if (idx >= ppcr_pkg::IDX_SCR_FIRST && idx <= ppcr_pkg::IDX_SCR_LAST) begin
         rd_byte = scratch_r[4'(idx - ppcr_pkg::IDX_SCR_FIRST)];
      end else begin
         unique case (idx)
            ppcr_pkg::IDX_STATUS: rd_byte = status;
            ppcr_pkg::IDX_REASON: rd_byte = reason_r;
            ppcr_pkg::IDX_TYPE: rd_byte = {TYPE_CODE[5:4], 2'b00, TYPE_CODE[3:0]};
            ppcr_pkg::IDX_SW_EN: rd_byte = sw_r;
            ppcr_pkg::IDX_LIN_A_EN: rd_byte = lin_a_r;
            ppcr_pkg::IDX_LIN_B_EN: rd_byte = lin_b_r;
            ppcr_pkg::IDX_SYNC: rd_byte = sync_r;
            ppcr_pkg::IDX_DL1_VOLT: rd_byte = v1_r;
            ppcr_pkg::IDX_DL2_VOLT: rd_byte = v2_r;
            default: hit = 1'b0;
         endcase
      end
   end

   // Zero wait: data is prepared in the setup cycle
   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel_in && !penable_in) begin
         prdata_r <= {24'h00_0000, rd_byte};
         pslverr_r <= ~hit;
      end
   end
   assign pready_out = psel_in & penable_in;
   assign prdata_out = prdata_r;
   assign pslverr_out = pslverr_r;

   // Writes to unmapped addresses do nothing
   assign wr = psel_in & penable_in & pwrite_in & pstrb_in[0] & hit;
   assign wd = pwdata_in[7:0];

   // Reason flags: set wins over a write-one clear
   assign reason_set = {key_override_evt_in, cold_off_evt_in, uvlo_evt_in,
                        state_r == ppcr_pkg::PPCR_ST_UP, glb_evt,
                        batt_insert_evt_in, chg_insert_evt_in, power_key_evt_in};
   assign reason_clr = (wr && idx == ppcr_pkg::IDX_REASON) ? wd : 8'h00;
   always_ff @(posedge clock_in) begin
      if (por_srst_in) begin
         reason_r <= 8'h00;
      end else begin
         reason_r <= (reason_r & ~reason_clr) | reason_set;
      end
   end

   // Scratch survives system reset
   always_ff @(posedge clock_in) begin
      if (por_srst_in) begin
         for (int i = 0; i < ppcr_pkg::SCR_COUNT; i++) begin
            scratch_r[i] <= 8'h00;
         end
      end else if (wr && idx >= ppcr_pkg::IDX_SCR_FIRST && idx <= ppcr_pkg::IDX_SCR_LAST) begin
         scratch_r[4'(idx - ppcr_pkg::IDX_SCR_FIRST)] <= wd;
      end
   end

   // Shadow control
   assign shadow_on = sync_r[ppcr_pkg::SYNC_SHADOW];
   assign xfer = wr && idx == ppcr_pkg::IDX_SYNC && wd[ppcr_pkg::SYNC_XFER];
   assign shadow_enter = wr && idx == ppcr_pkg::IDX_SYNC && !xfer &&
                         wd[ppcr_pkg::SYNC_SHADOW] && !shadow_on;
   assign live_wr = wr && !shadow_on;
   assign sh_wr = wr && shadow_on;

   // Control register; low-hold enable only follows power-on reset
   always_ff @(posedge clock_in) begin
      if (por_srst_in) begin
         low_hold_r <= ppcr_pkg::SYNC_RST[ppcr_pkg::SYNC_LOW_HOLD];
      end else if (wr && idx == ppcr_pkg::IDX_SYNC) begin
         low_hold_r <= wd[ppcr_pkg::SYNC_LOW_HOLD];
      end
   end
   // Bit 3 lives apart so that each part has a single writer
   assign sync_r = {sync_sys_r[6:3], low_hold_r, sync_sys_r[2:0]};
   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         sync_sys_r <= {ppcr_pkg::SYNC_RST[7:4], ppcr_pkg::SYNC_RST[2:0]};
      end else if (xfer) begin
         sync_sys_r[6:3] <= wd[7:4];
         sync_sys_r[2] <= wd[2] | sync_sys_r[2];
         sync_sys_r[1:0] <= 2'b00;
      end else if (wr && idx == ppcr_pkg::IDX_SYNC) begin
         sync_sys_r[6:3] <= wd[7:4];
         sync_sys_r[2] <= wd[2];
         sync_sys_r[1] <= wd[1];
         sync_sys_r[0] <= 1'b0;
      end else if (cold_req && state_r == ppcr_pkg::PPCR_ST_IDLE) begin
         // Enable is consumed so the sequence does not repeat forever
         sync_sys_r[2] <= 1'b0;
      end
   end

   // Live rail registers
   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         sw_r <= ppcr_pkg::SW_EN_RST;
         lin_a_r <= ppcr_pkg::LIN_A_RST;
         lin_b_r <= ppcr_pkg::LIN_B_RST;
         v1_r <= ppcr_pkg::DL1_VOLT_RST;
         v2_r <= ppcr_pkg::DL2_VOLT_RST;
      end else if (xfer) begin
         sw_r <= sh_sw_r;
         lin_a_r <= sh_lin_a_r;
         lin_b_r <= sh_lin_b_r;
         v1_r <= sh_v1_r;
         v2_r <= sh_v2_r;
      end else if (live_wr) begin
         if (idx == ppcr_pkg::IDX_SW_EN) sw_r <= wd & ppcr_pkg::SW_EN_MASK;
         if (idx == ppcr_pkg::IDX_LIN_A_EN) lin_a_r <= wd & ppcr_pkg::LIN_A_MASK;
         if (idx == ppcr_pkg::IDX_LIN_B_EN) lin_b_r <= wd & ppcr_pkg::LIN_B_MASK;
         if (idx == ppcr_pkg::IDX_DL1_VOLT) v1_r <= wd & ppcr_pkg::VOLT_MASK;
         if (idx == ppcr_pkg::IDX_DL2_VOLT) v2_r <= wd & ppcr_pkg::VOLT_MASK;
      end
   end

   // Shadow rail registers
   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         sh_sw_r <= ppcr_pkg::SW_EN_RST;
         sh_lin_a_r <= ppcr_pkg::LIN_A_RST;
         sh_lin_b_r <= ppcr_pkg::LIN_B_RST;
         sh_v1_r <= ppcr_pkg::DL1_VOLT_RST;
         sh_v2_r <= ppcr_pkg::DL2_VOLT_RST;
      end else if (shadow_enter) begin
         sh_sw_r <= sw_r;
         sh_lin_a_r <= lin_a_r;
         sh_lin_b_r <= lin_b_r;
         sh_v1_r <= v1_r;
         sh_v2_r <= v2_r;
      end else if (sh_wr) begin
         if (idx == ppcr_pkg::IDX_SW_EN) sh_sw_r <= wd & ppcr_pkg::SW_EN_MASK;
         if (idx == ppcr_pkg::IDX_LIN_A_EN) sh_lin_a_r <= wd & ppcr_pkg::LIN_A_MASK;
         if (idx == ppcr_pkg::IDX_LIN_B_EN) sh_lin_b_r <= wd & ppcr_pkg::LIN_B_MASK;
         if (idx == ppcr_pkg::IDX_DL1_VOLT) sh_v1_r <= wd & ppcr_pkg::VOLT_MASK;
         if (idx == ppcr_pkg::IDX_DL2_VOLT) sh_v2_r <= wd & ppcr_pkg::VOLT_MASK;
      end
   end

   // Platform reset held low while sleep-exit is high
   assign hold_cond = sync_r[ppcr_pkg::SYNC_LOW_HOLD] & pin_r[5] & ~pin_r[6];
   assign hold_fire = hold_cond && hold_cnt_r == ppcr_pkg::CNT_W'(LOW_HOLD_CYCLES - 1);
   always_ff @(posedge clock_in) begin
      if (sys_rst || !hold_cond) begin
         hold_cnt_r <= '0;
      end else if (hold_cnt_r != ppcr_pkg::CNT_W'(LOW_HOLD_CYCLES)) begin
         // Saturates so one long low fires once
         hold_cnt_r <= hold_cnt_r + 1'b1;
      end
   end

   assign cold_req = sync_r[ppcr_pkg::SYNC_COLD_EN] | hold_fire |
                     (glb_evt & sync_r[ppcr_pkg::SYNC_GLOBAL_COLD]);

   // Cold reset sequence; global and low-hold requests during it are dropped, a set bit 2 waits for idle
   always_ff @(posedge clock_in) begin
      if (sys_rst) begin
         state_r <= ppcr_pkg::PPCR_ST_IDLE;
         cold_cnt_r <= '0;
      end else begin
         unique case (state_r)
            ppcr_pkg::PPCR_ST_IDLE: begin
               cold_cnt_r <= '0;
               if (cold_req) begin
                  state_r <= ppcr_pkg::PPCR_ST_DOWN;
               end
            end
            ppcr_pkg::PPCR_ST_DOWN: begin
               cold_cnt_r <= cold_cnt_r + 1'b1;
               if (cold_cnt_r == ppcr_pkg::CNT_W'(COLD_DELAY_CYCLES - 1)) begin
                  state_r <= ppcr_pkg::PPCR_ST_UP;
               end
            end
            ppcr_pkg::PPCR_ST_UP: begin
               state_r <= ppcr_pkg::PPCR_ST_IDLE;
            end
         endcase
      end
   end

   // Rail enable outputs follow live registers unless the rails are held off; voltage outputs always follow
   assign rails_off_out = (state_r == ppcr_pkg::PPCR_ST_DOWN);
   assign switcher_en_out = rails_off_out ? 8'h00 : sw_r;
   assign linear_a_en_out = rails_off_out ? 8'h00 : lin_a_r;
   assign linear_b_en_out = rails_off_out ? 8'h00 : lin_b_r;
   assign digital_linear_one_volt_out = v1_r[4:0];
   assign digital_linear_two_volt_out = v2_r[4:0];
   assign switcher_five_dual_out = sync_r[ppcr_pkg::SYNC_DUAL_PHASE];
   assign switcher_three_four_poly_out = sync_r[ppcr_pkg::SYNC_POLY_PHASE];
   assign sleep_set_sel_out = sync_r[ppcr_pkg::SYNC_SLEEP_SET];

   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst);

   a_reason_sticky: assert property (
      reason_r[ppcr_pkg::RSN_KEY_OVR] && !reason_clr[ppcr_pkg::RSN_KEY_OVR]
      |=> reason_r[ppcr_pkg::RSN_KEY_OVR]) else $error("key override flag lost");
   a_reason_set_wins: assert property (
      power_key_evt_in |=> reason_r[ppcr_pkg::RSN_PWR_KEY]) else $error("start flag missed");
   a_cold_flag_up: assert property (
      state_r == ppcr_pkg::PPCR_ST_UP |=> reason_r[ppcr_pkg::RSN_COLD_RST])
      else $error("cold reset reason not set");
   a_status_low_zero: assert property (
      psel_in && !penable_in && idx == ppcr_pkg::IDX_STATUS |=> prdata_out[2:0] == 3'b000)
      else $error("status reserved bits not zero");
   a_type_code: assert property (
      psel_in && !penable_in && idx == ppcr_pkg::IDX_TYPE
      |=> prdata_out[7:0] == {TYPE_CODE[5:4], 2'b00, TYPE_CODE[3:0]}) else $error("type code");
   a_sw_reserved: assert property (
      (sw_r & ~ppcr_pkg::SW_EN_MASK) == 8'h00 && (lin_b_r & ~ppcr_pkg::LIN_B_MASK) == 8'h00)
      else $error("reserved enable bit set");
   a_xfer_clears: assert property (
      xfer |=> sync_r[1:0] == 2'b00 && sw_r == $past(sh_sw_r)) else $error("transfer failed");
   a_shadow_hold_live: assert property (
      sh_wr && idx == ppcr_pkg::IDX_SW_EN |=> $stable(sw_r)) else $error("live hit in shadow");
   a_rails_off_span: assert property (
      $rose(rails_off_out) |-> rails_off_out [*8]) else $error("rails off too short");
   a_global_cold: assert property (
      glb_evt && sync_r[ppcr_pkg::SYNC_GLOBAL_COLD] && state_r == ppcr_pkg::PPCR_ST_IDLE
      |=> rails_off_out) else $error("global reset not cold");
   a_hold_cold: assert property (
      hold_fire && state_r == ppcr_pkg::PPCR_ST_IDLE |=> rails_off_out)
      else $error("low hold did not reset");

   c_cold_cycle: cover property (state_r == ppcr_pkg::PPCR_ST_UP);
   c_shadow_xfer: cover property (shadow_on ##[1:20] xfer);
   c_reason_clear: cover property (reason_clr != 8'h00 && reason_r != 8'h00);
   c_err: cover property (pready_out && pslverr_out);
endmodule
`default_nettype wire

//--- rtl/ppcr_pkg.sv
package ppcr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h01;
   localparam logic [5:0] IDX_REASON = 6'h02;
   localparam logic [5:0] IDX_TYPE = 6'h03;
   localparam logic [5:0] IDX_SCR_FIRST = 6'h04;
   localparam logic [5:0] IDX_SCR_LAST = 6'h0f;
   localparam logic [5:0] IDX_SW_EN = 6'h10;
   localparam logic [5:0] IDX_LIN_A_EN = 6'h12;
   localparam logic [5:0] IDX_LIN_B_EN = 6'h13;
   localparam logic [5:0] IDX_SYNC = 6'h14;
   localparam logic [5:0] IDX_DL1_VOLT = 6'h15;
   localparam logic [5:0] IDX_DL2_VOLT = 6'h16;
   localparam int SCR_COUNT = 12;
   // Writable masks and reset values
   localparam logic [7:0] SW_EN_MASK = 8'h7b;
   localparam logic [7:0] SW_EN_RST = 8'h7b;
   localparam logic [7:0] LIN_A_MASK = 8'h7f;
   localparam logic [7:0] LIN_A_RST = 8'h08;
   localparam logic [7:0] LIN_B_MASK = 8'hfc;
   localparam logic [7:0] LIN_B_RST = 8'h9c;
   localparam logic [7:0] VOLT_MASK = 8'h1f;
   localparam logic [7:0] DL1_VOLT_RST = 8'h16;
   localparam logic [7:0] DL2_VOLT_RST = 8'h16;
   localparam logic [7:0] SYNC_RST = 8'h48;
   // Control register bit positions
   localparam int SYNC_GLOBAL_COLD = 7;
   localparam int SYNC_DUAL_PHASE = 6;
   localparam int SYNC_POLY_PHASE = 5;
   localparam int SYNC_SLEEP_SET = 4;
   localparam int SYNC_LOW_HOLD = 3;
   localparam int SYNC_COLD_EN = 2;
   localparam int SYNC_SHADOW = 1;
   localparam int SYNC_XFER = 0;
   // Reason register bit positions
   localparam int RSN_KEY_OVR = 7;
   localparam int RSN_COLD_OFF = 6;
   localparam int RSN_UVLO = 5;
   localparam int RSN_COLD_RST = 4;
   localparam int RSN_GLOBAL_RST = 3;
   localparam int RSN_BATT_INS = 2;
   localparam int RSN_CHG_INS = 1;
   localparam int RSN_PWR_KEY = 0;
   // Timing
   localparam int CLK_KHZ = 200000;
   localparam int COLD_DELAY_MS = 64;
   localparam int LOW_HOLD_MS = 512;
   localparam int CNT_W = 28;
   // Pin synchroniser lanes
   localparam int SYNC_LANES = 8;
   typedef enum logic [2:0] {
      PPCR_ST_IDLE = 3'b001,
      PPCR_ST_DOWN = 3'b010,
      PPCR_ST_UP = 3'b100
   } ppcr_state_t;
endpackage

//--- testbench/ppcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppcr_host_model (
   // Clock and commands
   input wire logic clock_in,
   input wire logic global_cmd_in,
   input wire logic hold_cmd_in,
   // Host pins
   output logic host_sleep_exit_n_out,
   output logic platform_reset_n_out,
   output logic host_global_reset_n_out
);
   logic [3:0] gr_cnt_r = 4'h0;
   // Low pulse kept long enough to pass the pin synchroniser
   always_ff @(posedge clock_in) begin
      if (global_cmd_in) begin
         gr_cnt_r <= 4'h8;
      end else if (gr_cnt_r != 4'h0) begin
         gr_cnt_r <= gr_cnt_r - 4'h1;
      end
   end
   assign host_global_reset_n_out = (gr_cnt_r == 4'h0);
   assign host_sleep_exit_n_out = hold_cmd_in;
   assign platform_reset_n_out = !hold_cmd_in;
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [5:0] TC = 6'h2a; // Arbitrary value
   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic por_srst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic [4:0] st = 5'h00;
   logic [5:0] ev = 6'h00;
   logic gcmd = 1'b0, hcmd = 1'b0;
   logic sx_n, pr_n, gr_n;
   logic [7:0] sw_en, lin_a, lin_b;
   logic [4:0] v1, v2;
   logic dual, poly, slp, off;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   // idx, reset value, write value, read-back value
   logic [31:0] rows [11] = '{
      32'h04_00_a5_a5,
      32'h0f_00_5a_5a,
      32'h10_7b_ff_7b,
      32'h12_08_ff_7f,
      32'h13_9c_ff_fc,
      32'h14_48_78_78,
      32'h15_16_ff_1f,
      32'h16_16_ff_1f,
      32'h01_00_ff_00,
      32'h02_00_00_00,
      {8'h03, TC[5:4], 2'b00, TC[3:0], 8'hff, TC[5:4], 2'b00, TC[3:0]}
   };
   always #2.5 clock_in = ~clock_in;
   ppcr_host_model i_ppcr_host_model (.clock_in(clock_in), .global_cmd_in(gcmd),
      .hold_cmd_in(hcmd), .host_sleep_exit_n_out(sx_n), .platform_reset_n_out(pr_n),
      .host_global_reset_n_out(gr_n));
   ppcr_regs #(.TYPE_CODE(TC), .COLD_DELAY_CYCLES(20), .LOW_HOLD_CYCLES(30)) i_ppcr_regs (
      .clock_in(clock_in), .srst_in(srst_in), .por_srst_in(por_srst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'h1), .pready_out(pready), .prdata_out(prdata),
      .pslverr_out(pslverr), .over_temp_in(st[4]), .charging_in(st[3]),
      .batt_present_in(st[2]), .batt_detect_done_in(st[1]), .batt_safe_mode_in(st[0]),
      .host_sleep_exit_n_in(sx_n), .platform_reset_n_in(pr_n),
      .host_global_reset_n_in(gr_n), .key_override_evt_in(ev[5]),
      .cold_off_evt_in(ev[4]), .uvlo_evt_in(ev[3]), .batt_insert_evt_in(ev[2]),
      .chg_insert_evt_in(ev[1]), .power_key_evt_in(ev[0]), .switcher_en_out(sw_en),
      .linear_a_en_out(lin_a), .linear_b_en_out(lin_b),
      .digital_linear_one_volt_out(v1), .digital_linear_two_volt_out(v2),
      .switcher_five_dual_out(dual), .switcher_three_four_poly_out(poly),
      .sleep_set_sel_out(slp), .rails_off_out(off));
   task automatic summarize();
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Master holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clock_in);
      penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees pready
      do begin
         @(posedge clock_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
   endtask
   // Waits for rails_off to reach v, counting cycles spent
   task automatic wait_off(input logic v);
      n = 0;
      while (off !== v && n < 200) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      chk({31'h0, off}, {31'h0, v});
   endtask
   task automatic resets(input logic por);
      @(posedge clock_in);
      srst_in <= 1'b1;
      por_srst_in <= por;
      repeat (5) @(posedge clock_in);
      srst_in <= 1'b0;
      por_srst_in <= 1'b0;
   endtask
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge clock_in);
      srst_in <= 1'b0;
      por_srst_in <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         rdchk(rows[i][29:24], rows[i][23:16]);
         apb(1'b1, rows[i][29:24], rows[i][15:8]);
         rdchk(rows[i][29:24], rows[i][7:0]);
         chk({31'h0, err}, 32'h0);
      end
      chk({dual, poly, slp, v1, v2}, {3'b111, 10'h3ff});
      st <= 5'b10110;
      repeat (6) @(posedge clock_in);
      rdchk(6'h01, 8'hb0);
      @(posedge clock_in);
      ev <= 6'h3f;
      @(posedge clock_in);
      ev <= 6'h00;
      rdchk(6'h02, 8'he7);
      apb(1'b1, 6'h02, 8'h81);
      rdchk(6'h02, 8'h66);
      apb(1'b1, 6'h02, 8'hff);
      rdchk(6'h02, 8'h00);
      apb(1'b0, 6'h11, 8'h00);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // Cold reset from the control bit
      apb(1'b1, 6'h14, 8'h4c);
      wait_off(1'b1);
      chk({24'h0, sw_en}, 32'h0);
      chk({16'h0, lin_a, lin_b}, 32'h0);
      wait_off(1'b0);
      chk(n, 20);
      chk({24'h0, sw_en}, 32'h7b);
      chk({16'h0, lin_a, lin_b}, 32'h7ffc);
      rdchk(6'h02, 8'h10);
      rdchk(6'h14, 8'h48);
      // Global reset only counts as cold reset with bit 7 set
      apb(1'b1, 6'h02, 8'hff);
      @(posedge clock_in);
      gcmd <= 1'b1;
      @(posedge clock_in);
      gcmd <= 1'b0;
      repeat (30) @(posedge clock_in);
      chk({31'h0, off}, 32'h0);
      apb(1'b1, 6'h02, 8'hff);
      apb(1'b1, 6'h14, 8'hc8);
      gcmd <= 1'b1;
      @(posedge clock_in);
      gcmd <= 1'b0;
      wait_off(1'b1);
      wait_off(1'b0);
      rdchk(6'h02, 8'h18);
      // Low hold must last the full count before firing
      apb(1'b1, 6'h02, 8'hff);
      @(posedge clock_in);
      hcmd <= 1'b1;
      repeat (20) @(posedge clock_in);
      #1;
      chk({31'h0, off}, 32'h0);
      wait_off(1'b1);
      wait_off(1'b0);
      hcmd <= 1'b0;
      rdchk(6'h02, 8'h10);
      // Shadow writes reach the rails only on transfer
      apb(1'b1, 6'h14, 8'h4a);
      apb(1'b1, 6'h10, 8'h00);
      @(posedge clock_in);
      chk({24'h0, sw_en}, 32'h7b);
      apb(1'b1, 6'h14, 8'h49);
      @(posedge clock_in);
      chk({24'h0, sw_en}, 32'h00);
      rdchk(6'h14, 8'h48);
      // System reset keeps scratch and low-hold enable, power-on clears scratch and sets low-hold enable
      apb(1'b1, 6'h14, 8'h40);
      resets(1'b0);
      rdchk(6'h04, 8'ha5);
      rdchk(6'h14, 8'h40);
      rdchk(6'h10, 8'h7b);
      rdchk(6'h02, 8'h10);
      resets(1'b1);
      rdchk(6'h04, 8'h00);
      rdchk(6'h14, 8'h48);
      rdchk(6'h02, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
